// ### rtl/tai_pkg.sv
// Package for the temperature alarm and interrupt logic: map, fields, resets, timing
package tai_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_CONFIGURATION = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STATUS_FIRST = 8'h01;
	localparam logic [7:0] ADDR_IRQ_STATUS_SECOND = 8'h02;
	localparam logic [7:0] ADDR_IRQ_MASK_FIRST = 8'h03;
	localparam logic [7:0] ADDR_IRQ_MASK_SECOND = 8'h04;
	localparam logic [7:0] ADDR_FAN_DIVISOR_PIN_SELECT = 8'h05;
	localparam logic [7:0] ADDR_OVERTEMP_CFG_RESOLUTION = 8'h06;
	localparam logic [7:0] ADDR_TEMPERATURE_READING = 8'h27;
	localparam logic [7:0] ADDR_HOT_LIMIT = 8'h38;
	localparam logic [7:0] ADDR_HOT_HYSTERESIS = 8'h39;
	localparam logic [7:0] ADDR_SHUTDOWN_LIMIT = 8'h3a;
	localparam logic [7:0] ADDR_SHUTDOWN_HYSTERESIS = 8'h3b;
	// Configuration fields
	localparam int CFG_START = 0;
	localparam int CFG_INT_ENABLE = 1;
	localparam int CFG_INT_POLARITY = 2;
	localparam int CFG_INT_CLEAR = 3;
	localparam int CFG_CHASSIS_CLEAR = 5;
	// Status / mask fields
	localparam int ST1_CASCADE_IN = 7;
	localparam int ST2_HOT = 0;
	localparam int ST2_BOARD_TEMP = 1;
	localparam int ST2_CHASSIS = 4;
	localparam int ST2_OVERTEMP = 5;
	localparam int MSK2_HOT_ONE_TIME = 6;
	localparam int MSK2_OVERTEMP_ONE_TIME = 7;
	localparam logic [7:0] MSK2_SOURCE_BITS = 8'h3f;
	// Pin select and resolution fields
	localparam int PIN_OVERTEMP_EN = 6;
	localparam int PIN_RESET_EN = 7;
	localparam int RES_12BIT = 0;
	localparam int RES_OVERTEMP_ONE_TIME = 2;
	localparam logic [7:0] RES_WRITABLE = 8'h0f;
	// Reset values
	localparam logic [7:0] RST_CONFIGURATION = 8'h08;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_FAN_DIVISOR_PIN_SELECT = 8'h14;
	localparam logic [7:0] RST_OVERTEMP_CFG_RESOLUTION = 8'h01;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_HOT_LIMIT = 8'h50;
	localparam logic [7:0] RST_HOT_HYSTERESIS = 8'h4b;
	localparam logic [7:0] RST_SHUTDOWN_LIMIT = 8'h5a;
	localparam logic [7:0] RST_SHUTDOWN_HYSTERESIS = 8'h55;
	// Timing
	localparam int CLK_HZ = 25_000_000;
	localparam int CHASSIS_CLEAR_MS = 10;
	localparam int CHASSIS_CLEAR_CYCLES = (CLK_HZ / 1000) * CHASSIS_CLEAR_MS;
	localparam int CNT_W = 18;
	// Register port request and answer
	typedef struct packed {
		logic wr;
		logic rd;
		logic word;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tai_req_t;
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} tai_rsp_t;
endpackage

// ### rtl/tai_temp_alarm.sv
// Temperature alarm comparison and interrupt aggregation with its register file
`timescale 1ns/10ps
`default_nettype none
module tai_temp_alarm #(
	parameter int CHASSIS_CLEAR_CYC = tai_pkg::CHASSIS_CLEAR_CYCLES
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Register port
	input wire tai_pkg::tai_req_t i_reg_req,
	output tai_pkg::tai_rsp_t o_reg_rsp,
	// Temperature converter results, 12-bit left aligned
	input wire logic [11:0] i_temp_raw,
	input wire logic i_temp_done,
	// External interrupt sources (pins)
	input wire logic i_board_temp_irq_in_n,
	input wire logic i_cascade_irq_in_n,
	input wire logic i_chassis_intrusion_in,
	// Chassis intrusion line drive (open drain, low only)
	output logic o_chassis_intrusion_out,
	output logic o_chassis_intrusion_oe,
	// Interrupt pin (open drain or open source)
	output logic o_int_out,
	output logic o_int_oe,
	// Shared reset/overtemp pin, active low
	output logic o_reset_or_overtemp_pin_n
);
	import tai_pkg::*;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] st1;
		logic [7:0] st2;
		logic [7:0] msk1;
		logic [7:0] msk2;
		logic [7:0] pinsel;
		logic [3:0] res;
		logic [11:0] temp;
		logic [7:0] hot_lim;
		logic [7:0] hot_hyst;
		logic [7:0] os_lim;
		logic [7:0] os_hyst;
		logic hot_active;
		logic hot_armed;
		logic os_armed;
		logic os_cmp;
		logic int_req;
		logic [2:0] bti_sync;
		logic [2:0] cas_sync;
		logic [2:0] ci_sync;
		logic bti_lvl;
		logic cas_lvl;
		logic ci_lvl;
		logic [CNT_W-1:0] ci_cnt;
		tai_rsp_t rsp;
		logic int_out;
		logic int_oe;
		logic ci_oe;
		logic os_pin_n;
	} tai_state_t;

	tai_state_t state_ff;
	tai_state_t nxt_state;

	// Signed 8-bit compare shared by all limit checks
	function automatic logic sgt(input logic [7:0] a, input logic [7:0] b);
		sgt = $signed(a) > $signed(b);
	endfunction

	// Any status bit that its mask lets through; mask2 top bits are mode bits, never masks
	function automatic logic any_unmasked(input logic [7:0] s1, input logic [7:0] m1, input logic [7:0] s2, input logic [7:0] m2);
		any_unmasked = (|(s1 & ~m1)) | (|(s2 & ~m2 & MSK2_SOURCE_BITS));
	endfunction

	logic [7:0] temp_byte;
	logic [7:0] res_rd;
	logic [7:0] rd_byte;
	logic [11:0] conv;
	logic [7:0] conv_byte;
	logic monitor;
	logic above_hot;
	logic below_hot_hyst;
	logic above_os;
	logic below_os_hyst;
	logic [7:0] set1;
	logic [7:0] set2;
	logic [7:0] clr1;
	logic [7:0] clr2;
	logic pending;
	logic int_active;
	logic status_rd;

	// Readback views of the temperature
	assign temp_byte = state_ff.temp[11:4];
	assign res_rd = {state_ff.temp[3:0], state_ff.res};

	// Read mux
	always_comb begin
		case (i_reg_req.addr)
			ADDR_CONFIGURATION: rd_byte = state_ff.cfg;
			ADDR_IRQ_STATUS_FIRST: rd_byte = state_ff.st1;
			ADDR_IRQ_STATUS_SECOND: rd_byte = state_ff.st2;
			ADDR_IRQ_MASK_FIRST: rd_byte = state_ff.msk1;
			ADDR_IRQ_MASK_SECOND: rd_byte = state_ff.msk2;
			ADDR_FAN_DIVISOR_PIN_SELECT: rd_byte = state_ff.pinsel;
			ADDR_OVERTEMP_CFG_RESOLUTION: rd_byte = res_rd;
			ADDR_TEMPERATURE_READING: rd_byte = temp_byte;
			ADDR_HOT_LIMIT: rd_byte = state_ff.hot_lim;
			ADDR_HOT_HYSTERESIS: rd_byte = state_ff.hot_hyst;
			ADDR_SHUTDOWN_LIMIT: rd_byte = state_ff.os_lim;
			ADDR_SHUTDOWN_HYSTERESIS: rd_byte = state_ff.os_hyst;
			default: rd_byte = 8'h00;
		endcase
	end

	// Conversion result trimmed to the selected resolution
	always_comb begin
		if (state_ff.res[RES_12BIT]) begin
			conv = i_temp_raw;
		end else begin
			conv = {i_temp_raw[11:3], 3'h0};
		end
	end
	assign conv_byte = conv[11:4];

	// Monitoring stops while not started or while the clear bit is held
	assign monitor = state_ff.cfg[CFG_START] & ~state_ff.cfg[CFG_INT_CLEAR];

	// 8-bit compares against the four limits
	assign above_hot = sgt(conv_byte, state_ff.hot_lim);
	assign below_hot_hyst = sgt(state_ff.hot_hyst, conv_byte);
	assign above_os = sgt(conv_byte, state_ff.os_lim);
	assign below_os_hyst = sgt(state_ff.os_hyst, conv_byte);

	// Unmasked status reaches the interrupt; mask2 top bits are mode bits, not masks
	assign pending = any_unmasked(state_ff.st1, state_ff.msk1, state_ff.st2, state_ff.msk2);
	assign int_active = state_ff.int_req & state_ff.cfg[CFG_INT_ENABLE] & ~state_ff.cfg[CFG_INT_CLEAR];
	// A read of either status register drops the interrupt, even while the other still holds bits
	assign status_rd = i_reg_req.rd & ((i_reg_req.addr == ADDR_IRQ_STATUS_FIRST) |
		(i_reg_req.addr == ADDR_IRQ_STATUS_SECOND));

	// Next state
	always_comb begin
		nxt_state = state_ff;
		set1 = 8'h00;
		set2 = 8'h00;
		clr1 = 8'h00;
		clr2 = 8'h00;

		// Pin synchronisers; a level counts once stages two and three agree
		nxt_state.bti_sync = {state_ff.bti_sync[1:0], i_board_temp_irq_in_n};
		nxt_state.cas_sync = {state_ff.cas_sync[1:0], i_cascade_irq_in_n};
		nxt_state.ci_sync = {state_ff.ci_sync[1:0], i_chassis_intrusion_in};
		if (state_ff.bti_sync[1] == state_ff.bti_sync[2]) begin
			nxt_state.bti_lvl = state_ff.bti_sync[2];
		end
		if (state_ff.cas_sync[1] == state_ff.cas_sync[2]) begin
			nxt_state.cas_lvl = state_ff.cas_sync[2];
		end
		if (state_ff.ci_sync[1] == state_ff.ci_sync[2]) begin
			nxt_state.ci_lvl = state_ff.ci_sync[2];
		end

		// External sources; sticky while the level persists
		set2[ST2_BOARD_TEMP] = ~state_ff.bti_lvl;
		set1[ST1_CASCADE_IN] = ~state_ff.cas_lvl;
		// Ignore our own pull-down so the clear pulse does not look like intrusion
		set2[ST2_CHASSIS] = state_ff.ci_lvl & ~state_ff.ci_oe;

		// Temperature evaluation on each finished conversion while monitoring
		if (i_temp_done && monitor) begin
			nxt_state.temp = conv;
			if (state_ff.msk2[MSK2_HOT_ONE_TIME]) begin
				// One-time: fire once, re-arm below hysteresis
				if (above_hot && state_ff.hot_armed) begin
					set2[ST2_HOT] = 1'b1;
					nxt_state.hot_armed = 1'b0;
				end else if (below_hot_hyst) begin
					nxt_state.hot_armed = 1'b1;
				end
			end else begin
				// Default: re-fire every conversion while hot, auto-clear below hysteresis
				if (above_hot) begin
					nxt_state.hot_active = 1'b1;
				end else if (below_hot_hyst) begin
					nxt_state.hot_active = 1'b0;
					clr2[ST2_HOT] = 1'b1;
				end
				set2[ST2_HOT] = above_hot | (state_ff.hot_active & ~below_hot_hyst);
			end
			// Overtemp status bit: default or one-time per mask2 bit 7
			if (state_ff.msk2[MSK2_OVERTEMP_ONE_TIME]) begin
				if (above_os && state_ff.os_armed) begin
					set2[ST2_OVERTEMP] = 1'b1;
					nxt_state.os_armed = 1'b0;
				end else if (below_os_hyst) begin
					nxt_state.os_armed = 1'b1;
				end
			end else begin
				if (below_os_hyst) begin
					clr2[ST2_OVERTEMP] = 1'b1;
				end
				set2[ST2_OVERTEMP] = above_os | (state_ff.os_cmp & ~below_os_hyst);
			end
			// Comparator tracking for the overtemp pin
			if (above_os) begin
				nxt_state.os_cmp = 1'b1;
			end else if (below_os_hyst) begin
				nxt_state.os_cmp = 1'b0;
			end
		end

		// Register reads; a status read clears it after returning contents
		nxt_state.rsp.valid = i_reg_req.rd;
		if (i_reg_req.rd) begin
			nxt_state.rsp.data = {8'h00, rd_byte};
			if (i_reg_req.word && i_reg_req.addr == ADDR_TEMPERATURE_READING) begin
				nxt_state.rsp.data = {temp_byte, state_ff.temp[3:0], 4'h0};
			end
			if (i_reg_req.addr == ADDR_IRQ_STATUS_FIRST) begin
				clr1 = 8'hff;
			end
			if (i_reg_req.addr == ADDR_IRQ_STATUS_SECOND) begin
				clr2 = 8'hff;
			end
		end

		// Status update: a new event wins over a clear in the same cycle
		nxt_state.st1 = (state_ff.st1 & ~clr1) | set1;
		nxt_state.st2 = ((state_ff.st2 & ~clr2) | set2) & MSK2_SOURCE_BITS;

		// Interrupt request: a fresh unmasked event raises it and wins; a status read or empty status drops it
		nxt_state.int_req = any_unmasked(set1, state_ff.msk1, set2, state_ff.msk2)
			| (state_ff.int_req & ~status_rd & pending);

		// Chassis clear pulse counts down before the writes, so a new request in the last cycle wins
		if (state_ff.ci_cnt != '0) begin
			nxt_state.ci_cnt = state_ff.ci_cnt - CNT_W'(1);
			if (state_ff.ci_cnt == CNT_W'(1)) begin
				nxt_state.cfg[CFG_CHASSIS_CLEAR] = 1'b0;
			end
		end

		// Register writes
		if (i_reg_req.wr) begin
			case (i_reg_req.addr)
				ADDR_CONFIGURATION: begin
					nxt_state.cfg = i_reg_req.wdata;
					if (i_reg_req.wdata[CFG_CHASSIS_CLEAR]) begin
						nxt_state.ci_cnt = CNT_W'(CHASSIS_CLEAR_CYC);
					end
				end
				ADDR_IRQ_MASK_FIRST: nxt_state.msk1 = i_reg_req.wdata;
				ADDR_IRQ_MASK_SECOND: nxt_state.msk2 = i_reg_req.wdata;
				ADDR_FAN_DIVISOR_PIN_SELECT: nxt_state.pinsel = i_reg_req.wdata;
				ADDR_OVERTEMP_CFG_RESOLUTION: nxt_state.res = i_reg_req.wdata[3:0] & RES_WRITABLE[3:0];
				ADDR_HOT_LIMIT: nxt_state.hot_lim = i_reg_req.wdata;
				ADDR_HOT_HYSTERESIS: nxt_state.hot_hyst = i_reg_req.wdata;
				ADDR_SHUTDOWN_LIMIT: nxt_state.os_lim = i_reg_req.wdata;
				ADDR_SHUTDOWN_HYSTERESIS: nxt_state.os_hyst = i_reg_req.wdata;
				default: ;
			endcase
		end

		// Pull the chassis line low while the count runs
		nxt_state.ci_oe = (nxt_state.ci_cnt != '0);

		// Interrupt pin: drive to the active level only while asserted
		nxt_state.int_out = nxt_state.cfg[CFG_INT_POLARITY];
		nxt_state.int_oe = int_active;

		// Shared pin: overtemp function only when selected; one-time follows status bit
		if (state_ff.pinsel[PIN_OVERTEMP_EN] && !state_ff.pinsel[PIN_RESET_EN]) begin
			if (state_ff.res[RES_OVERTEMP_ONE_TIME]) begin
				nxt_state.os_pin_n = ~state_ff.st2[ST2_OVERTEMP];
			end else begin
				nxt_state.os_pin_n = ~state_ff.os_cmp;
			end
		end else begin
			nxt_state.os_pin_n = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			state_ff <= '0;
			state_ff.cfg <= RST_CONFIGURATION;
			state_ff.st1 <= RST_STATUS;
			state_ff.st2 <= RST_STATUS;
			state_ff.msk1 <= RST_MASK;
			state_ff.msk2 <= RST_MASK;
			state_ff.pinsel <= RST_FAN_DIVISOR_PIN_SELECT;
			state_ff.res <= RST_OVERTEMP_CFG_RESOLUTION[3:0];
			state_ff.hot_lim <= RST_HOT_LIMIT;
			state_ff.hot_hyst <= RST_HOT_HYSTERESIS;
			state_ff.os_lim <= RST_SHUTDOWN_LIMIT;
			state_ff.os_hyst <= RST_SHUTDOWN_HYSTERESIS;
			state_ff.hot_armed <= 1'b1;
			state_ff.os_armed <= 1'b1;
			// Idle pin levels so no false event follows reset
			state_ff.bti_sync <= 3'h7;
			state_ff.cas_sync <= 3'h7;
			state_ff.bti_lvl <= 1'b1;
			state_ff.cas_lvl <= 1'b1;
			state_ff.os_pin_n <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from flops; the chassis drive level is a constant low
	assign o_reg_rsp = state_ff.rsp;
	assign o_int_out = state_ff.int_out;
	assign o_int_oe = state_ff.int_oe;
	assign o_chassis_intrusion_out = 1'b0;
	assign o_chassis_intrusion_oe = state_ff.ci_oe;
	assign o_reset_or_overtemp_pin_n = state_ff.os_pin_n;
endmodule
`default_nettype wire

// ### verification/tai_asserts.sv
// Port checker for the temperature alarm and interrupt block
`timescale 1ns/10ps
`default_nettype none
module tai_asserts import tai_pkg::*; #(
	parameter int CHASSIS_CLEAR_CYC = 20
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Register port
	input wire tai_pkg::tai_req_t i_reg_req,
	input wire tai_pkg::tai_rsp_t o_reg_rsp,
	// Pins driven by the block
	input wire logic o_chassis_intrusion_out,
	input wire logic o_chassis_intrusion_oe,
	input wire logic o_int_out,
	input wire logic o_int_oe,
	input wire logic o_reset_or_overtemp_pin_n
);
	logic [7:0] cfg_ff;
	logic [7:0] pin_ff;
	int cnt_ff;
	logic int_off;
	logic pin_off;
	logic cfg_wr;
	// Shadows of the gating registers; the self-clearing bit is never used here
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			cfg_ff <= RST_CONFIGURATION;
			pin_ff <= RST_FAN_DIVISOR_PIN_SELECT;
			cnt_ff <= 0;
		end else begin
			if (cfg_wr)
				cfg_ff <= i_reg_req.wdata;
			if (i_reg_req.wr && i_reg_req.addr == ADDR_FAN_DIVISOR_PIN_SELECT)
				pin_ff <= i_reg_req.wdata;
			cnt_ff <= o_chassis_intrusion_oe ? cnt_ff + 1 : 0;
		end
	end
	// Conditions under which a pin must stay quiet
	assign cfg_wr = i_reg_req.wr && i_reg_req.addr == ADDR_CONFIGURATION;
	assign int_off = !cfg_ff[CFG_INT_ENABLE] || cfg_ff[CFG_INT_CLEAR];
	assign pin_off = !pin_ff[PIN_OVERTEMP_EN] || pin_ff[PIN_RESET_EN];
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);
	a_read_answer: assert property (i_reg_req.rd |=> o_reg_rsp.valid)
		else $error("read not answered one cycle later");
	a_no_stray_answer: assert property (!i_reg_req.rd |=> !o_reg_rsp.valid)
		else $error("answer without a read");
	a_byte_upper_zero: assert property (i_reg_req.rd && !i_reg_req.word |=> o_reg_rsp.data[15:8] == 8'h00)
		else $error("byte read with upper byte set");
	a_word_low_zero: assert property (i_reg_req.rd && i_reg_req.word && i_reg_req.addr == ADDR_TEMPERATURE_READING
		|=> o_reg_rsp.data[3:0] == 4'h0)
		else $error("word read low nibble not zero");
	a_int_off_quiet: assert property (int_off && $past(int_off) && $past(int_off, 2) |-> !o_int_oe)
		else $error("interrupt driven while disabled or cleared");
	a_int_level_pol: assert property (cfg_wr |=> ##1 o_int_out == $past(i_reg_req.wdata[CFG_INT_POLARITY], 2))
		else $error("interrupt drive level not the polarity bit");
	a_pin_idle_high: assert property (pin_off && $past(pin_off) && $past(pin_off, 2) |-> o_reset_or_overtemp_pin_n)
		else $error("shared pin low while overtemp unselected");
	a_ci_drive_low: assert property (!o_chassis_intrusion_out)
		else $error("chassis line driven high");
	a_ci_start: assert property (cfg_wr && i_reg_req.wdata[CFG_CHASSIS_CLEAR] && !o_chassis_intrusion_oe
		|=> o_chassis_intrusion_oe)
		else $error("chassis pull did not start");
	a_ci_length: assert property ($fell(o_chassis_intrusion_oe) |-> cnt_ff == CHASSIS_CLEAR_CYC)
		else $error("chassis pull of wrong length");
	a_ci_bound: assert property (o_chassis_intrusion_oe |-> cnt_ff < CHASSIS_CLEAR_CYC)
		else $error("chassis pull too long");
	c_status_read: cover property (i_reg_req.rd && i_reg_req.addr == ADDR_IRQ_STATUS_SECOND);
	c_int_rise: cover property ($rose(o_int_oe));
	c_ci_end: cover property ($fell(o_chassis_intrusion_oe));
	c_overtemp: cover property (!o_reset_or_overtemp_pin_n);
endmodule
bind tai_temp_alarm tai_asserts #(.CHASSIS_CLEAR_CYC(CHASSIS_CLEAR_CYC)) u_chk (.i_core_clk(i_core_clk),
	.i_rstn(i_rstn), .i_reg_req(i_reg_req), .o_reg_rsp(o_reg_rsp), .o_chassis_intrusion_out(o_chassis_intrusion_out),
	.o_chassis_intrusion_oe(o_chassis_intrusion_oe), .o_int_out(o_int_out), .o_int_oe(o_int_oe),
	.o_reset_or_overtemp_pin_n(o_reset_or_overtemp_pin_n));
`default_nettype wire

// ### verification/tai_far_end.sv
// Far side model: temperature converter and external interrupt sources
`timescale 1ns/10ps
`default_nettype none
module tai_far_end (
	// Clock
	input wire logic i_core_clk,
	// Commands from the bench, plus the block's chassis pull enable
	input wire logic i_go,
	input wire logic [11:0] i_temp,
	input wire logic [3:0] i_delay,
	input wire logic i_bti_low,
	input wire logic i_casc_low,
	input wire logic i_ci_high,
	input wire logic i_ci_oe,
	// Results and pin levels toward the block
	output logic [11:0] o_temp_raw,
	output logic o_temp_done,
	output logic o_bti_n,
	output logic o_casc_n,
	output logic o_ci
);
	logic [4:0] wait_ff = 5'h00;
	logic done_ff = 1'b0;
	logic [11:0] tmp_ff = 12'h000;
	// Conversion finishes after a chosen delay, prompt or slow
	always @(posedge i_core_clk) begin
		done_ff <= 1'b0;
		if (i_go) begin
			wait_ff <= {1'b0, i_delay} + 5'h01;
			tmp_ff <= i_temp;
		end else if (wait_ff == 5'h01) begin
			wait_ff <= 5'h00;
			done_ff <= 1'b1;
		end else if (wait_ff != 5'h00) begin
			wait_ff <= wait_ff - 5'h01;
		end
	end
	// Result is only valid with the strobe; otherwise a changed pattern
	assign o_temp_done = done_ff;
	assign o_temp_raw = done_ff ? tmp_ff : ~tmp_ff;
	// Pull-up on the board-temperature line when the source lets go
	assign o_bti_n = !i_bti_low;
	assign o_casc_n = !i_casc_low;
	// Wired level: the block's pull-low wins over the external latch
	assign o_ci = i_ci_oe ? 1'b0 : i_ci_high;
endmodule
`default_nettype wire

// ### verification/temp_alarm_interrupt_logic_tb_top.sv
// Self-checking testbench for the temperature alarm and interrupt block
`timescale 1ns/10ps
`default_nettype none
module temp_alarm_interrupt_logic_tb_top import tai_pkg::*;;
	localparam int CLR = 20;
	logic clk, rstn, go, board_temp_irq_in, casc, cih, done, btin, cascn, ci, ci_out, ci_oe, int_out, int_oe, pin_n;
	logic [11:0] ptemp, raw, t;
	logic [3:0] pdly;
	logic [7:0] v;
	tai_req_t req;
	tai_rsp_t rsp;
	int n_errors = 0;
	int cmp_count = 0;
	int seed = 32'h1e2dc883;
	logic [7:0] ra [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h27, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h10};
	logic [7:0] rv [13] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01, 8'h00, 8'h50, 8'h4b, 8'h5a, 8'h55, 8'h00};
	logic [7:0] lim [4] = '{8'h20, 8'h1c, 8'h40, 8'h3c};
	tai_temp_alarm #(.CHASSIS_CLEAR_CYC(CLR)) dut (.i_core_clk(clk), .i_rstn(rstn), .i_reg_req(req), .o_reg_rsp(rsp),
		.i_temp_raw(raw), .i_temp_done(done), .i_board_temp_irq_in_n(btin), .i_cascade_irq_in_n(cascn),
		.i_chassis_intrusion_in(ci), .o_chassis_intrusion_out(ci_out), .o_chassis_intrusion_oe(ci_oe),
		.o_int_out(int_out), .o_int_oe(int_oe), .o_reset_or_overtemp_pin_n(pin_n));
	tai_far_end u_far (.i_core_clk(clk), .i_go(go), .i_temp(ptemp), .i_delay(pdly), .i_bti_low(board_temp_irq_in),
		.i_casc_low(casc), .i_ci_high(cih), .i_ci_oe(ci_oe), .o_temp_raw(raw), .o_temp_done(done),
		.o_bti_n(btin), .o_casc_n(cascn), .o_ci(ci));
	// Free-running core clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Expected double-byte temperature for either resolution
	function automatic logic [15:0] wexp(input logic [11:0] x, input logic nine);
		return nine ? {x[11:3], 7'h00} : {x, 4'h0};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkp(input string nm, input logic e, input logic g);
		chk(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	// Each bus task ends one edge after releasing, so strobes never toggle twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic w, output logic [15:0] d);
		int k;
		req.rd = 1'b1;
		req.addr = a;
		req.word = w;
		@(negedge clk);
		req.rd = 1'b0;
		k = 0;
		while (rsp.valid !== 1'b1 && k < 4) begin
			@(negedge clk);
			k++;
		end
		d = (k < 4) ? rsp.data : 16'hxxxx;
		@(negedge clk);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic w, input logic [15:0] e);
		logic [15:0] d;
		rd(a, w, d);
		chk(nm, e, d);
	endtask
	task automatic clr_status();
		logic [15:0] d;
		rd(8'h01, 1'b0, d);
		rd(8'h02, 1'b0, d);
		repeat (2) @(negedge clk);
	endtask
	// One conversion; status lands one edge after the strobe, pins one more
	task automatic conv(input logic [11:0] x);
		int k;
		ptemp = x;
		pdly = 4'($random(seed));
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chkp("conversion done", 1'b1, done);
		repeat (3) @(negedge clk);
	endtask
	task automatic final_report();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard, well past the expected run length
	initial begin
		#(40 * 8000);
		n_errors++;
		final_report();
	end
	initial begin
		req = '0;
		{go, board_temp_irq_in, casc, cih, rstn} = 5'h00;
		ptemp = 12'h000;
		pdly = 4'h0;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		foreach (ra[i]) rchk("reset value", ra[i], 1'b0, {8'h00, rv[i]});
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(8'h38 + 8'(i), v);
			rchk("limit", 8'h38 + 8'(i), 1'b0, {8'h00, v});
			wr(8'h38 + 8'(i), lim[i]);
		end
		wr(8'h00, 8'h01);
		t = 12'($random(seed));
		conv(t);
		wr(8'h27, 8'h5a);
		rchk("temp byte", 8'h27, 1'b0, {8'h00, t[11:4]});
		rchk("temp low bits", 8'h06, 1'b0, {8'h00, t[3:0], 4'h1});
		rchk("temp word", 8'h27, 1'b1, wexp(t, 1'b0));
		wr(8'h06, 8'h00);
		conv(t);
		rchk("temp word nine", 8'h27, 1'b1, wexp(t, 1'b1));
		wr(8'h06, 8'h01);
		wr(8'h00, 8'h07);
		chkp("int level", 1'b1, int_out);
		wr(8'h00, 8'h03);
		clr_status();
		conv(12'h280);
		chkp("int on hot", 1'b1, int_oe);
		rchk("hot status", 8'h02, 1'b0, 16'h0001);
		repeat (2) @(negedge clk);
		chkp("int after read", 1'b0, int_oe);
		conv(12'h280);
		chkp("int again", 1'b1, int_oe);
		conv(12'h100);
		chkp("int auto clear", 1'b0, int_oe);
		conv(12'h280);
		rchk("first status empty", 8'h01, 1'b0, 16'h0000);
		repeat (2) @(negedge clk);
		chkp("int after first read", 1'b0, int_oe);
		conv(12'h280);
		wr(8'h00, 8'h0b);
		repeat (3) @(negedge clk);
		chkp("int cleared", 1'b0, int_oe);
		rchk("status kept", 8'h02, 1'b0, 16'h0001);
		wr(8'h00, 8'h03);
		conv(12'h100);
		wr(8'h04, 8'h40);
		conv(12'h280);
		chkp("one time int", 1'b1, int_oe);
		clr_status();
		conv(12'h280);
		chkp("one time quiet", 1'b0, int_oe);
		conv(12'h100);
		conv(12'h280);
		chkp("one time rearmed", 1'b1, int_oe);
		wr(8'h04, 8'h00);
		conv(12'h100);
		clr_status();
		wr(8'h05, 8'h40);
		conv(12'h480);
		chkp("overtemp low", 1'b0, pin_n);
		rchk("overtemp status", 8'h02, 1'b0, 16'h0021);
		conv(12'h3e0);
		chkp("overtemp held", 1'b0, pin_n);
		conv(12'h100);
		chkp("overtemp released", 1'b1, pin_n);
		wr(8'h06, 8'h05);
		conv(12'h480);
		rchk("one time pin status", 8'h02, 1'b0, 16'h0021);
		repeat (2) @(negedge clk);
		chkp("one time pin high", 1'b1, pin_n);
		wr(8'h06, 8'h01);
		wr(8'h05, 8'hc0);
		conv(12'h480);
		chkp("pin unselected", 1'b1, pin_n);
		wr(8'h05, 8'h14);
		conv(12'h100);
		clr_status();
		wr(8'h03, 8'h80);
		casc = 1'b1;
		repeat (10) @(negedge clk);
		chkp("cascade masked", 1'b0, int_oe);
		casc = 1'b0;
		repeat (10) @(negedge clk);
		rchk("cascade sticky", 8'h01, 1'b0, 16'h0080);
		wr(8'h03, 8'h00);
		casc = 1'b1;
		repeat (10) @(negedge clk);
		chkp("cascade int", 1'b1, int_oe);
		casc = 1'b0;
		repeat (10) @(negedge clk);
		clr_status();
		chkp("int after clear", 1'b0, int_oe);
		wr(8'h04, 8'h02);
		board_temp_irq_in = 1'b1;
		repeat (10) @(negedge clk);
		chkp("board masked", 1'b0, int_oe);
		board_temp_irq_in = 1'b0;
		repeat (10) @(negedge clk);
		rchk("board status", 8'h02, 1'b0, 16'h0002);
		wr(8'h04, 8'h10);
		cih = 1'b1;
		repeat (10) @(negedge clk);
		chkp("chassis masked", 1'b0, int_oe);
		cih = 1'b0;
		repeat (10) @(negedge clk);
		rchk("chassis status", 8'h02, 1'b0, 16'h0010);
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h23);
		chkp("chassis pulling", 1'b1, ci_oe);
		repeat (CLR + 2) @(negedge clk);
		chkp("chassis released", 1'b0, ci_oe);
		rchk("chassis bit self clear", 8'h00, 1'b0, 16'h0003);
		chkp("chassis drive level", 1'b0, ci_out);
		casc = 1'b1;
		repeat (10) @(negedge clk);
		casc = 1'b0;
		chkp("cascade before reset", 1'b1, int_oe);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		chkp("int after reset", 1'b0, int_oe);
		rchk("status after reset", 8'h01, 1'b0, 16'h0000);
		final_report();
	end
endmodule
`default_nettype wire
